// ===== logic/ees_slave.sv
/*
  Bus-slave front end of a serial memory: address match against straps,
  write protect, power-up readiness, internal write cycle and the data path
  of written bytes into a small FIFO. The bit engine runs on the serial clock;
  start, stop and timing run on mclk. Assumes a bus controller that drives
  the serial clock and keeps data stable while the clock is high.
*/
`timescale 1ns/100ps
`default_nettype none
module ees_slave #(
  parameter int PWRUP_CYCLES = ees_pkg::PWRUP_CYC,
  parameter int WRITE_CYCLES = ees_pkg::WRCYC_CYC,
  parameter bit HAS_WP = 1'b1
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic ser_clk,
  input wire logic scl_level,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic addr_select_bit0,
  input wire logic addr_select_bit1,
  input wire logic addr_select_bit2,
  input wire logic wp_pin,
  output logic [ees_pkg::BYTE_W-1:0] wdata,
  output logic wdata_valid,
  input wire logic wdata_ready,
  output logic ready,
  output logic write_busy
);
  localparam int SYNC_W = 7;
  localparam int TW = ees_pkg::TIMER_W;

  typedef struct packed {
    ees_pkg::ees_frame_e st;
    logic run;
    logic pscl;
    logic psda;
    logic [TW-1:0] pwr_cnt;
    logic ready;
    logic busy;
    logic [TW-1:0] wr_cnt;
    logic got_data;
    logic tog_s1;
    logic tog_s2;
    logic tog_s3;
    logic hold_v;
    logic [ees_pkg::BYTE_W-1:0] hold;
  } ees_main_s;

  // Link-side state that must survive between frames.
  typedef struct packed {
    logic [SYNC_W-1:0] s1;
    logic [SYNC_W-1:0] s2;
    logic push_tog;
    logic [ees_pkg::BYTE_W-1:0] hold;
  } ees_keep_s;

  // Link-side state that is cleared outside every frame.
  typedef struct packed {
    logic [3:0] bit_cnt;
    logic [ees_pkg::BYTE_W-1:0] shift;
    logic [1:0] byte_idx;
    logic selected;
    logic is_read;
    logic data_seen;
    logic ack;
  } ees_link_s;

  typedef struct packed {
    logic oe;
    logic wp_blk;
    logic od_low;
  } ees_neg_s;

  ees_main_s m_r;
  ees_main_s m_nxt;
  ees_keep_s k_r;
  ees_keep_s k_nxt;
  ees_link_s l_r;
  ees_link_s l_nxt;
  ees_neg_s n_r;
  ees_neg_s n_nxt;

  logic scl_f;
  logic sda_f;
  logic start_det;
  logic stop_det;
  logic byte_evt;
  logic fifo_in_ready;
  logic link_rst_n;
  logic push_now;
  logic addr_match;
  logic [ees_pkg::BYTE_W-1:0] byte_now;
  logic [ees_pkg::STRAP_W-1:0] strap_s;
  logic wp_s;
  logic rdy_s;
  logic busy_s;
  logic room_s;

  ees_deglitch #(.STABLE(ees_pkg::FILT_STABLE)) u_flt_scl (
    .clk(mclk),
    .rst_n(resetn),
    .din(scl_level),
    .dout(scl_f)
  );

  ees_deglitch #(.STABLE(ees_pkg::FILT_STABLE)) u_flt_sda (
    .clk(mclk),
    .rst_n(resetn),
    .din(sda_in),
    .dout(sda_f)
  );

  ees_fifo #(.W(ees_pkg::BYTE_W), .DEPTH(ees_pkg::FIFO_DEPTH)) u_fifo (
    .clk(mclk),
    .rst_n(resetn),
    .in_valid(m_r.hold_v),
    .in_ready(fifo_in_ready),
    .in_data(m_r.hold),
    .out_valid(wdata_valid),
    .out_ready(wdata_ready),
    .out_data(wdata)
  );

  // Start and stop are judged on filtered lines, so short pulses never frame a transfer.
  assign start_det = m_r.pscl && scl_f && m_r.psda && !sda_f;
  assign stop_det = m_r.pscl && scl_f && !m_r.psda && sda_f;
  assign byte_evt = m_r.tog_s3 ^ m_r.tog_s2;

  always_comb begin
    m_nxt = m_r;
    m_nxt.pscl = scl_f;
    m_nxt.psda = sda_f;
    m_nxt.tog_s1 = k_r.push_tog;
    m_nxt.tog_s2 = m_r.tog_s1;
    m_nxt.tog_s3 = m_r.tog_s2;
    if (m_r.hold_v && fifo_in_ready) begin
      m_nxt.hold_v = 1'b0;
    end
    // The link holds its byte for a whole byte time, so it is stable when the toggle lands.
    if (byte_evt) begin
      m_nxt.hold_v = 1'b1;
      m_nxt.hold = k_r.hold;
      m_nxt.got_data = 1'b1;
    end
    if (!m_r.ready) begin
      if (m_r.pwr_cnt == TW'(PWRUP_CYCLES - 1)) begin
        m_nxt.ready = 1'b1;
      end else begin
        m_nxt.pwr_cnt = m_r.pwr_cnt + TW'(1);
      end
    end
    if (m_r.busy) begin
      if (m_r.wr_cnt == TW'(WRITE_CYCLES - 1)) begin
        m_nxt.busy = 1'b0;
      end else begin
        m_nxt.wr_cnt = m_r.wr_cnt + TW'(1);
      end
    end
    case (m_r.st)
      ees_pkg::EES_IDLE: begin
        if (start_det) begin
          m_nxt.st = ees_pkg::EES_START;
        end
      end
      ees_pkg::EES_START: begin
        if (stop_det) begin
          m_nxt.st = ees_pkg::EES_IDLE;
        end else if (!scl_f) begin
          m_nxt.st = ees_pkg::EES_FRAME;
        end
      end
      ees_pkg::EES_FRAME: begin
        if (start_det) begin
          m_nxt.st = ees_pkg::EES_START;
        end else if (stop_det) begin
          m_nxt.st = ees_pkg::EES_IDLE;
          m_nxt.got_data = 1'b0;
          if (m_r.got_data || byte_evt) begin
            m_nxt.busy = 1'b1;
            m_nxt.wr_cnt = '0;
          end
        end
      end
      default: begin
        m_nxt.st = ees_pkg::EES_IDLE;
      end
    endcase
    m_nxt.run = m_nxt.st == ees_pkg::EES_FRAME;
  end

  // Power-on reset is the only reset of this main state and clears it all to standby.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      m_r <= '{st: ees_pkg::EES_IDLE, run: 1'b0, pscl: ees_pkg::FILT_IDLE, psda: ees_pkg::FILT_IDLE,
               pwr_cnt: '0, ready: 1'b0, busy: 1'b0, wr_cnt: '0, got_data: 1'b0, tog_s1: 1'b0,
               tog_s2: 1'b0, tog_s3: 1'b0, hold_v: 1'b0, hold: '0};
    end else begin
      m_r <= m_nxt;
    end
  end

  assign ready = m_r.ready;
  assign write_busy = m_r.busy;

  // The link engine is held in reset outside frames; release happens with the serial clock low.
  assign link_rst_n = resetn & m_r.run;

  assign strap_s = k_r.s2[2:0];
  assign wp_s = k_r.s2[3];
  assign rdy_s = k_r.s2[4];
  assign busy_s = k_r.s2[5];
  assign room_s = k_r.s2[6];
  assign byte_now = {l_r.shift[ees_pkg::BYTE_W-2:0], sda_in};
  // Straps have internal pull-downs, so an open strap arrives here as low.
  assign addr_match = byte_now[7:4] == ees_pkg::ADDR_PREFIX && byte_now[3:1] == strap_s
                      && rdy_s && !busy_s;

  always_comb begin
    k_nxt = k_r;
    k_nxt.s1 = {!m_r.hold_v, m_r.busy, m_r.ready, wp_pin,
                addr_select_bit2, addr_select_bit1, addr_select_bit0};
    k_nxt.s2 = k_r.s1;
    if (push_now) begin
      k_nxt.push_tog = !k_r.push_tog;
      k_nxt.hold = byte_now;
    end
  end

  always_ff @(posedge ser_clk or negedge resetn) begin
    if (!resetn) begin
      k_r <= '0;
    end else begin
      k_r <= k_nxt;
    end
  end

  always_comb begin
    l_nxt = l_r;
    push_now = 1'b0;
    if (l_r.bit_cnt == ees_pkg::BIT_ACK) begin
      l_nxt.bit_cnt = ees_pkg::BIT_FIRST;
      l_nxt.ack = 1'b0;
      if (l_r.byte_idx != ees_pkg::IDX_DATA) begin
        l_nxt.byte_idx = l_r.byte_idx + 2'h1;
      end
    end else begin
      l_nxt.shift = byte_now;
      l_nxt.bit_cnt = l_r.bit_cnt + 4'h1;
      if (l_r.bit_cnt == ees_pkg::BIT_LAST) begin
        if (l_r.byte_idx == ees_pkg::IDX_SLAVE) begin
          l_nxt.selected = addr_match;
          l_nxt.is_read = sda_in;
          l_nxt.ack = addr_match;
        end else if (l_r.selected && !l_r.is_read) begin
          if (l_r.byte_idx != ees_pkg::IDX_DATA) begin
            l_nxt.ack = 1'b1;
          end else begin
            l_nxt.data_seen = 1'b1;
            // A protected or overfull write is refused by withholding the acknowledge.
            l_nxt.ack = !n_r.wp_blk && room_s;
            push_now = l_nxt.ack;
          end
        end
      end
    end
  end

  always_ff @(posedge ser_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      l_r <= '0;
    end else begin
      l_r <= l_nxt;
    end
  end

  // Output changes only on the falling edge, so data is stable while the clock is high.
  always_comb begin
    n_nxt = n_r;
    n_nxt.oe = l_r.ack;
    n_nxt.od_low = 1'b0;
    if (l_r.byte_idx == ees_pkg::IDX_DATA && l_r.bit_cnt == ees_pkg::BIT_FIRST && !l_r.data_seen) begin
      // The pin has a pull-down, so an open input reads low and leaves writes enabled.
      n_nxt.wp_blk = HAS_WP && wp_s;
    end
  end

  always_ff @(negedge ser_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      n_r <= '0;
    end else begin
      n_r <= n_nxt;
    end
  end

  assign sda_oe = n_r.oe;
  assign sda_out = n_r.od_low;

  logic [TW-1:0] up_cnt;
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      up_cnt <= '0;
    end else if (up_cnt != '1) begin
      up_cnt <= up_cnt + TW'(1);
    end
  end

  a_sample_rise: assert property (@(posedge ser_clk) disable iff (!link_rst_n)
    l_r.bit_cnt < ees_pkg::BIT_ACK |=> l_r.shift[0] == $past(sda_in))
    else $error("data bit not taken on the rising clock edge");
  a_drive_fall: assert property (@(posedge ser_clk) disable iff (!link_rst_n)
    sda_oe == l_r.ack)
    else $error("data output did not follow the acknowledge at the falling edge");
  a_open_drain: assert property (@(posedge mclk) disable iff (!resetn)
    sda_out == 1'b0)
    else $error("data line driven high");
  a_addr_match: assert property (@(posedge ser_clk) disable iff (!link_rst_n)
    l_r.bit_cnt == ees_pkg::BIT_LAST && l_r.byte_idx == ees_pkg::IDX_SLAVE
    |=> l_r.ack == ($past(byte_now[7:1]) == {ees_pkg::ADDR_PREFIX, $past(strap_s)} && $past(rdy_s) && !$past(busy_s)))
    else $error("slave address acknowledge does not follow the strap match");
  a_wp_refuse: assert property (@(posedge ser_clk) disable iff (!link_rst_n)
    l_r.bit_cnt == ees_pkg::BIT_LAST && l_r.byte_idx == ees_pkg::IDX_DATA && n_r.wp_blk
    |=> !l_r.ack && k_r.push_tog == $past(k_r.push_tog))
    else $error("protected write byte was accepted");
  a_wp_variant: assert property (@(posedge ser_clk) disable iff (!link_rst_n)
    $rose(n_r.wp_blk) |-> HAS_WP && wp_s)
    else $error("write protect latched without a protect input driven high");
  a_busy_nack: assert property (@(posedge ser_clk) disable iff (!link_rst_n)
    l_r.bit_cnt == ees_pkg::BIT_LAST && l_r.byte_idx == ees_pkg::IDX_SLAVE && busy_s |=> !l_r.ack)
    else $error("address acknowledged during internal write");
  a_pwrup_ready: assert property (@(posedge mclk) disable iff (!resetn)
    ready == (up_cnt >= TW'(PWRUP_CYCLES)))
    else $error("ready not raised exactly at the power-up delay");
  a_write_end: assert property (@(posedge mclk) disable iff (!resetn)
    $fell(write_busy) |-> $past(m_r.wr_cnt) == TW'(WRITE_CYCLES - 1))
    else $error("internal write cycle length wrong");
  a_stop_write: assert property (@(posedge mclk) disable iff (!resetn)
    m_r.st == ees_pkg::EES_FRAME && stop_det && m_r.got_data |=> write_busy)
    else $error("stop after data did not start the internal write");

  c_addr_ack: cover property (@(posedge ser_clk) disable iff (!link_rst_n)
    l_r.byte_idx == ees_pkg::IDX_SLAVE && l_r.ack);
  c_data_push: cover property (@(posedge mclk) disable iff (!resetn) byte_evt);
  c_write_cycle: cover property (@(posedge mclk) disable iff (!resetn) $rose(write_busy));
  c_wp_block: cover property (@(posedge ser_clk) disable iff (!link_rst_n) n_r.wp_blk);
endmodule
`default_nettype wire

// ===== logic/ees_pkg.sv
/*
  Shared constants for the serial memory slave front end: timing counts,
  slave address layout, byte and bit positions, and the frame state type.
  Assumes a 125 MHz main clock; all counts are derived from that period.
*/
`default_nettype none
package ees_pkg;
  localparam int CLK_PERIOD_NS = 8;
  // Pulses up to this width on either bus line must not be seen.
  localparam int GLITCH_NS = 100;
  localparam int GLITCH_CYC = GLITCH_NS / CLK_PERIOD_NS;
  // A pulse of GLITCH_NS can cover GLITCH_CYC + 1 samples, so one sample more is needed to pass.
  localparam int FILT_STABLE = GLITCH_CYC + 2;
  localparam int PWRUP_MS = 1;
  localparam int PWRUP_CYC = PWRUP_MS * 1_000_000 / CLK_PERIOD_NS;
  localparam int WRCYC_MS = 5;
  localparam int WRCYC_CYC = WRCYC_MS * 1_000_000 / CLK_PERIOD_NS;
  localparam int TIMER_W = 20;
  localparam int FILT_W = 5;
  localparam int BYTE_W = 8;
  localparam int STRAP_W = 3;
  localparam int FIFO_DEPTH = 4;
  localparam logic [3:0] ADDR_PREFIX = 4'hA;
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_ACK = 4'h8;
  localparam logic [3:0] BIT_FIRST = 4'h0;
  localparam logic [1:0] IDX_SLAVE = 2'h0;
  localparam logic [1:0] IDX_DATA = 2'h3;
  localparam logic FILT_IDLE = 1'b1;
  typedef enum logic [1:0] {EES_IDLE, EES_START, EES_FRAME} ees_frame_e;
endpackage
`default_nettype wire

// ===== logic/ees_deglitch.sv
/*
  Two-flop synchroniser followed by a stability filter for one bus line.
  Assumes the line idles high, as an open-drain bus with pull-ups does.
*/
`timescale 1ns/100ps
`default_nettype none
module ees_deglitch #(
  parameter int STABLE = ees_pkg::FILT_STABLE
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic din,
  output logic dout
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic [ees_pkg::FILT_W-1:0] cnt;
    logic q;
  } ees_flt_s;

  ees_flt_s r_r;
  ees_flt_s r_nxt;

  // The output moves only after the input has held a new level for STABLE samples.
  always_comb begin
    r_nxt = r_r;
    r_nxt.s1 = din;
    r_nxt.s2 = r_r.s1;
    if (r_r.s2 == r_r.q) begin
      r_nxt.cnt = '0;
    end else if (r_r.cnt == ees_pkg::FILT_W'(STABLE - 1)) begin
      r_nxt.q = r_r.s2;
      r_nxt.cnt = '0;
    end else begin
      r_nxt.cnt = r_r.cnt + ees_pkg::FILT_W'(1);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r_r <= '{s1: ees_pkg::FILT_IDLE, s2: ees_pkg::FILT_IDLE, cnt: '0, q: ees_pkg::FILT_IDLE};
    end else begin
      r_r <= r_nxt;
    end
  end

  assign dout = r_r.q;

  a_glitch_stable: assert property (@(posedge clk) disable iff (!rst_n)
    !$stable(r_r.q) |-> $past(r_r.cnt) == ees_pkg::FILT_W'(STABLE - 1) && $past(r_r.s2) == r_r.q)
    else $error("filtered line changed before the input was stable long enough");
endmodule
`default_nettype wire

// ===== logic/ees_fifo.sv
/*
  Small synchronous FIFO with valid and ready on both sides.
  Assumes DEPTH is a power of two and one clock for both sides.
*/
`timescale 1ns/100ps
`default_nettype none
module ees_fifo #(
  parameter int W = ees_pkg::BYTE_W,
  parameter int DEPTH = ees_pkg::FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [PW:0] wp;
    logic [PW:0] rp;
  } ees_fifo_s;

  ees_fifo_s f_r;
  ees_fifo_s f_nxt;
  logic full;
  logic empty;

  assign empty = f_r.wp == f_r.rp;
  assign full = f_r.wp == {~f_r.rp[PW], f_r.rp[PW-1:0]};

  always_comb begin
    f_nxt = f_r;
    if (in_valid && !full) begin
      f_nxt.mem[f_r.wp[PW-1:0]] = in_data;
      f_nxt.wp = f_r.wp + (PW + 1)'(1);
    end
    if (out_ready && !empty) begin
      f_nxt.rp = f_r.rp + (PW + 1)'(1);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      f_r <= '0;
    end else begin
      f_r <= f_nxt;
    end
  end

  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = f_r.mem[f_r.rp[PW-1:0]];

  a_fifo_count: assert property (@(posedge clk) disable iff (!rst_n)
    (f_r.wp - f_r.rp) <= (PW + 1)'(DEPTH))
    else $error("fifo occupancy beyond its depth");
endmodule
`default_nettype wire

// ===== testbench/ees_master.sv
/*
  Behavioural two-wire bus controller that drives the serial clock.
  Assumes the bench resolves the data wire with a pull-up from all drivers.
*/
`timescale 1ns/100ps
`default_nettype none
module ees_master (
  output logic scl,
  output logic sda_low,
  input wire logic sda
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // Start, stop and the first low phase are held long so the line
  // filters see them; bits then run at the 30 ns link period.
  task automatic start();
    #200 sda_low = 1'b1;
    #200 scl = 1'b0;
    #200;
  endtask
  // Address bytes are sent as prefix, select bits, direction, MSB first.
  task automatic put_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      #7 sda_low = ~b[i];
      #8 scl = 1'b1;
      #15 scl = 1'b0;
    end
    #7 sda_low = 1'b0;
    #8 ack = (sda === 1'b0);
    scl = 1'b1;
    #15 scl = 1'b0;
  endtask
  // The clock stands high between frames; an optional short pulse on the
  // data line mimics a false stop before the real one.
  task automatic stop(input bit glitch);
    #7 sda_low = 1'b1;
    #8 scl = 1'b1;
    #200;
    if (glitch) begin
      sda_low = 1'b0;
      #80 sda_low = 1'b1;
      #200;
    end
    sda_low = 1'b0;
    #300;
  endtask
endmodule
`default_nettype wire

// ===== testbench/ees_slave_tb.sv
/*
  Self-checking bench for the serial memory slave front end.
  Assumes the bus controller model in ees_master and short power-up and
  write-cycle counts; no command is sent before ready is seen high.
*/
`timescale 1ns/100ps
`default_nettype none
module ees_slave_tb;
  localparam int PWR = 50;
  localparam int WRC = 200;
  localparam int LIMIT = 40000;
  logic mclk;
  logic resetn;
  logic [2:0] strap;
  logic wp;
  logic pop;
  logic so;
  logic oe;
  logic [7:0] wdata;
  logic wv;
  logic rdy;
  logic busy;
  wire scl;
  wire sda_low;
  wire sda;
  int error_cnt = 0;
  int checked = 0;
  int cyc = 0;
  int blen = 0;
  int last_len = 0;

  // Pull-up on the data wire: low only when someone pulls it low.
  assign sda = !(sda_low || (oe && !so));

  always #4 mclk = ~mclk;

  ees_master u_m (.scl(scl), .sda_low(sda_low), .sda(sda));

  ees_slave #(.PWRUP_CYCLES(PWR), .WRITE_CYCLES(WRC), .HAS_WP(1'b1)) DUT (
    .mclk(mclk), .resetn(resetn), .ser_clk(scl), .scl_level(scl),
    .sda_in(sda), .sda_out(so), .sda_oe(oe),
    .addr_select_bit0(strap[0]), .addr_select_bit1(strap[1]),
    .addr_select_bit2(strap[2]), .wp_pin(wp), .wdata(wdata),
    .wdata_valid(wv), .wdata_ready(pop), .ready(rdy), .write_busy(busy)
  );

  task automatic summarize();
    if (error_cnt == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  always @(oe) if (resetn === 1'b1) chk("oe change clock", 8'h00, {7'h0, scl});

  // Busy length is measured here so that polling frames can run meanwhile.
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (oe === 1'b1) chk("drive value", 8'h00, {7'h0, so});
    if (busy === 1'b1) blen <= blen + 1;
    else if (blen != 0) begin
      last_len <= blen;
      blen <= 0;
    end
    if (cyc == LIMIT) begin
      error_cnt++;
      summarize();
    end
  end

  task automatic xfer(input logic [7:0] b, input logic exp);
    logic a;
    u_m.put_byte(b, a);
    chk("ack", {7'h0, exp}, {7'h0, a});
  endtask

  task automatic wr_head();
    u_m.start();
    xfer({4'hA, strap, 1'b0}, 1'b1);
    xfer(8'h00, 1'b1);
    xfer(8'h10, 1'b1);
  endtask

  task automatic pop_chk(input logic [7:0] exp);
    @(posedge mclk);
    chk("wdata", exp, wdata);
    chk("wdata valid", 8'h01, {7'h0, wv});
    pop <= 1'b1;
    @(posedge mclk) pop <= 1'b0;
  endtask

  task automatic wait_idle();
    int n = 0;
    while (busy === 1'b1 && n < 2 * WRC) begin
      @(posedge mclk);
      n++;
    end
    @(posedge mclk);
    chk("busy length", 8'(WRC), last_len[7:0]);
  endtask

  task automatic s_power();
    @(posedge mclk) resetn <= 1'b0;
    repeat (12) @(posedge mclk);
    chk("outputs in reset", 8'h00, {4'h0, rdy, busy, wv, oe});
    resetn <= 1'b1;
    repeat (PWR) @(posedge mclk);
    chk("ready early", 8'h00, {7'h0, rdy});
    @(posedge mclk);
    chk("ready", 8'h01, {7'h0, rdy});
  endtask

  task automatic s_addr();
    for (int s = 0; s < 8; s++) begin
      @(posedge mclk) strap <= s[2:0];
      u_m.start();
      xfer({4'hA, s[2:0], 1'b1}, 1'b1);
      u_m.stop(1'b0);
      u_m.start();
      xfer({4'hA, s[2:0] ^ (3'h1 << (s % 3)), 1'b1}, 1'b0);
      u_m.stop(1'b0);
    end
    u_m.start();
    xfer({4'hB, strap, 1'b0}, 1'b0);
    u_m.stop(1'b0);
  endtask

  task automatic s_write();
    @(posedge mclk) strap <= 3'h5;
    wr_head();
    xfer(8'hA5, 1'b1);
    xfer(8'h3C, 1'b1);
    fork
      u_m.stop(1'b1);
      begin
        #480 chk("busy after glitch", 8'h00, {7'h0, busy});
      end
    join
    chk("busy after stop", 8'h01, {7'h0, busy});
    u_m.start();
    xfer({4'hA, strap, 1'b0}, 1'b0);
    u_m.stop(1'b0);
    pop_chk(8'hA5);
    pop_chk(8'h3C);
    wait_idle();
    u_m.start();
    xfer({4'hA, strap, 1'b0}, 1'b1);
    u_m.stop(1'b0);
  endtask

  task automatic s_wp();
    @(posedge mclk) wp <= 1'b1;
    wr_head();
    xfer(8'h77, 1'b0);
    xfer(8'h78, 1'b0);
    u_m.stop(1'b0);
    repeat (30) @(posedge mclk);
    chk("protected write", 8'h00, {6'h0, busy, wv});
    wp <= 1'b0;
    // Protect rising after the strobe edge must not reject this frame.
    wr_head();
    @(posedge mclk) wp <= 1'b1;
    xfer(8'h99, 1'b1);
    u_m.stop(1'b0);
    @(posedge mclk) wp <= 1'b0;
    pop_chk(8'h99);
    wait_idle();
  endtask

  task automatic s_fifo();
    wr_head();
    for (int i = 0; i < 6; i++) xfer(8'hC0 + i[7:0], i < 5);
    u_m.stop(1'b0);
    for (int i = 0; i < 5; i++) pop_chk(8'hC0 + i[7:0]);
    @(posedge mclk);
    chk("fifo empty", 8'h00, {7'h0, wv});
    wait_idle();
  endtask

  initial begin
    // Reset leaves the unknown state by a real falling edge, so the serial-clock flops clear too.
    mclk = 1'b0;
    resetn <= 1'b0;
    strap <= 3'h0;
    wp <= 1'b0;
    pop <= 1'b0;
    s_power();
    s_addr();
    s_write();
    s_wp();
    s_fifo();
    s_power();
    summarize();
  end
endmodule
`default_nettype wire
